// File: logic/ptq_num_fifo.sv
// ptq_num_fifo: small flip-flop fifo of packet numbers with peek at the head.
// a push when full or a pop when empty is ignored, so the owner need not guard either.
`timescale 1ns/1ps
module ptq_num_fifo
  import ptq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // fifo side
  ptq_fifo_if.fifo f
);
  logic [PNUM_W-1:0] mem_ff [FIFO_DEPTH];
  logic [PIDX_W-1:0] rd_ff;
  logic [PIDX_W-1:0] wr_ff;
  logic [CNT_W-1:0] cnt_ff;
  wire do_push = f.push && !f.full;
  wire do_pop = f.pop && !f.empty;

  assign f.head = mem_ff[rd_ff];
  assign f.empty = (cnt_ff == '0);
  assign f.full = (cnt_ff == CNT_W'(FIFO_DEPTH));
  assign f.last = (cnt_ff == CNT_W'(1));

  // storage, no reset needed on the data words
  always_ff @(posedge clk)
  begin
    if (do_push)
      mem_ff[wr_ff] <= f.wdata;
  end

  // pointers and count
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_ff <= '0;
      wr_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (do_push)
        wr_ff <= wr_ff + PIDX_W'(1);
      if (do_pop)
        rd_ff <= rd_ff + PIDX_W'(1);
      cnt_ff <= cnt_ff + CNT_W'(do_push) - CNT_W'(do_pop);
    end
  end
endmodule : ptq_num_fifo

// File: logic/ptq_top.sv
// ptq_top: transmit queue control: allocator, tx fifo, completion fifo, duplex modes.
// assumes host commands are one-cycle pulses synchronous to clk and the mac
// answers each start with exactly one done pulse.
// Notes on behaviour
// - ram pages are one pool shared by transmit and receive, per-packet on demand.
// - selected packet appears at one port; a pointer reaches any byte.
// - diagnostic duplex loops transmit back to receive, still using csma/cd.
// - switched full duplex runs paths apart with carrier sense disabled.
// - switched full duplex never loops transmit back internally.
// - switched full duplex never defers; only the interframe gap separates frames.
// - switched full duplex performs no collision detection.
// - allocate of n bytes tries to reserve that many bytes of ram.
// - success sets alloc done flag and puts the number in the result.
// - enqueue pushes the packet number register into the transmit fifo.
// - start only with transmit enable set and, in half duplex, deferral clear.
// - without auto release, status word goes into the packet's first word.
// - without auto release, completion moves the number to the completion fifo.
// - transmit interrupt is high while the completion fifo holds entries.
// - failure raises transmit interrupt, clears transmit enable, stops the queue.
// - after failure the failed number shows at the transmit fifo port.
// - release command frees the packet's memory and number.
// - acknowledge with transmit interrupt bit pops the completion fifo.
// - with auto release, successful completion frees pages without host help.
// - with auto release, drained flag rises when the queued sequence completes.
// - transmit interrupt always equals inverse of completion fifo empty.
`timescale 1ns/1ps
module ptq_top
  import ptq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // host command port
  input wire ptq_pkg::ptq_cmd_t host_cmd,
  input wire logic [LEN_W-1:0] host_alloc_len,
  input wire logic [PNUM_W-1:0] host_pnum_wr,
  input wire logic host_pnum_we,
  input wire logic [PTR_W-1:0] host_ptr_wr,
  input wire logic host_ptr_we,
  input wire logic host_ack_tx_int,
  input wire logic host_ack_drained,
  // host configuration bits
  input wire logic transmit_enable_set,
  input wire logic diag_loopback_duplex,
  input wire logic switched_full_duplex,
  input wire logic auto_release,
  // receive side page requests
  input wire logic rx_page_req,
  input wire logic rx_page_free,
  // mac side
  input wire logic mac_defer,
  input wire logic mac_done,
  input wire logic mac_fail,
  input wire logic [STAT_W-1:0] mac_status,
  // host status
  output logic transmit_enable_bit,
  output logic alloc_done_flag,
  output logic alloc_failed,
  output logic [PNUM_W-1:0] alloc_result,
  output logic [PNUM_W-1:0] pnum_reg,
  output logic [PTR_W-1:0] data_addr,
  output logic tx_int,
  output logic completion_fifo_empty,
  output logic [PNUM_W-1:0] tx_fifo_port,
  output logic tx_queue_drained_flag,
  output logic rx_page_grant,
  // mac controls
  output logic mac_start,
  output logic [PNUM_W-1:0] mac_pnum,
  output logic mac_loopback,
  output logic mac_carrier_sense_en,
  output logic mac_collision_en,
  // status word write into packet ram
  output logic stat_we,
  output logic [PNUM_W-1:0] stat_pnum,
  output logic [PTR_W-1:0] stat_addr,
  output logic [STAT_W-1:0] stat_data
);
  ptq_fifo_if txq ();
  ptq_fifo_if cmpq ();

  ptq_num_fifo u_txq (.clk(clk), .rstn(rstn), .f(txq));
  ptq_num_fifo u_cmpq (.clk(clk), .rstn(rstn), .f(cmpq));

  // per-packet bookkeeping, flip-flops indexed by packet number
  logic [NPKT-1:0] in_use_ff;
  logic [PAGE_W-1:0] pages_ff [NPKT];
  logic [PAGE_W-1:0] free_pages_ff;
  ptq_state_t state_ff;
  logic [IFG_W-1:0] gap_ff;
  logic [PNUM_W-1:0] cur_ff;
  logic [PNUM_W-1:0] nxt_pnum;

  // pages needed for n bytes, rounded up
  function automatic logic [PAGE_W-1:0] pages_for(input logic [LEN_W-1:0] n);
    logic [LEN_W:0] t;
    t = {1'b0, n} + (LEN_W+1)'(PAGE_BYTES - 1);
    pages_for = PAGE_W'(t >> $clog2(PAGE_BYTES));
  endfunction : pages_for

  // pool index from a packet number
  function automatic logic [PIDX_W-1:0] pidx(input logic [PNUM_W-1:0] p);
    pidx = p[PIDX_W-1:0];
  endfunction : pidx

  // lowest free packet number
  logic [PIDX_W-1:0] free_idx;
  logic any_free;
  always_comb
  begin
    free_idx = '0;
    any_free = 1'b0;
    for (int i = NPKT - 1; i >= 0; i--)
      if (!in_use_ff[i])
      begin
        free_idx = PIDX_W'(i);
        any_free = 1'b1;
      end
  end

  // command decode
  wire alloc_cmd = (host_cmd == PTQ_CMD_ALLOC);
  wire enq_cmd = (host_cmd == PTQ_CMD_ENQ);
  wire rel_cmd = (host_cmd == PTQ_CMD_RELEASE);
  wire [PAGE_W-1:0] need_pages = pages_for(host_alloc_len);
  wire rx_take = rx_page_req && (free_pages_ff != '0);
  wire [PAGE_W-1:0] avail_tx = free_pages_ff - PAGE_W'(rx_take);
  wire alloc_ok = alloc_cmd && any_free && (need_pages <= avail_tx)
                  && (need_pages != '0);
  wire done_ok = (state_ff == PTQ_BUSY) && mac_done && !mac_fail;
  wire done_bad = (state_ff == PTQ_BUSY) && mac_done && mac_fail;
  wire auto_free = done_ok && auto_release;
  wire host_free = rel_cmd && in_use_ff[pidx(pnum_reg)];
  wire full_duplex = switched_full_duplex;
  // half duplex waits for deferral; switched mode ignores it
  wire may_start = transmit_enable_bit && !txq.empty &&
                   (full_duplex || !mac_defer);
  wire [PAGE_W-1:0] freed_auto = auto_free ? pages_ff[pidx(cur_ff)] : '0;
  wire [PAGE_W-1:0] freed_host = host_free ? pages_ff[pidx(pnum_reg)] : '0;
  wire [PAGE_W-1:0] rx_back = PAGE_W'(rx_page_free);
  wire [PAGE_W-1:0] taken = alloc_ok ? need_pages : '0;

  // failure is held as a completion-like entry until acknowledged
  logic fail_pend_ff;
  wire fail_int_nxt = fail_pend_ff || done_bad;
  // emptiness one cycle ahead, head ahead only on a push into an empty fifo, so the registered flags track the fifo
  wire cmpq_empty_nxt = cmpq.empty ? !cmpq.push : (cmpq.pop && !cmpq.push && cmpq.last);
  wire [PNUM_W-1:0] cmpq_head_nxt = cmpq.empty ? cmpq.wdata : cmpq.head;
  // queue drains when its last entry leaves with nothing arriving
  wire drain_evt = auto_free && txq.last && !txq.push;

  // fifo handshakes
  assign txq.push = enq_cmd && !txq.full;
  assign txq.wdata = pnum_reg;
  // every finished frame leaves the queue, so a re-enqueue never sends twice;
  // the failed number is kept in cur_ff for the port
  assign txq.pop = done_ok || done_bad;
  assign cmpq.push = done_ok && !auto_release && !cmpq.full;
  assign cmpq.wdata = cur_ff;
  assign cmpq.pop = host_ack_tx_int;
  assign nxt_pnum = host_pnum_we ? host_pnum_wr : pnum_reg;

  // packet pool and page accounting
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      in_use_ff <= '0;
      free_pages_ff <= PAGE_W'(NPAGE);
      for (int i = 0; i < NPKT; i++)
        pages_ff[i] <= '0;
    end
    else
    begin
      free_pages_ff <= free_pages_ff - taken - PAGE_W'(rx_take) + freed_auto
                       + freed_host + rx_back;
      if (alloc_ok)
      begin
        in_use_ff[free_idx] <= 1'b1;
        pages_ff[free_idx] <= need_pages;
      end
      if (auto_free)
        in_use_ff[pidx(cur_ff)] <= 1'b0;
      if (host_free)
        in_use_ff[pidx(pnum_reg)] <= 1'b0;
    end
  end

  // allocation result and host-visible selection
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      alloc_done_flag <= 1'b0;
      alloc_failed <= 1'b0;
      alloc_result <= PNUM_NONE;
      pnum_reg <= PNUM_NONE;
      data_addr <= '0;
      rx_page_grant <= 1'b0;
    end
    else
    begin
      if (alloc_cmd)
      begin
        alloc_done_flag <= alloc_ok;
        alloc_failed <= !alloc_ok;
      end
      if (alloc_ok)
        alloc_result <= PNUM_W'(free_idx);
      pnum_reg <= nxt_pnum;
      if (host_ptr_we)
        data_addr <= host_ptr_wr;
      rx_page_grant <= rx_take;
    end
  end

  // transmit sequencer
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff <= PTQ_IDLE;
      cur_ff <= PNUM_NONE;
      gap_ff <= '0;
      transmit_enable_bit <= 1'b0;
      mac_start <= 1'b0;
      mac_pnum <= PNUM_NONE;
    end
    else
    begin
      mac_start <= 1'b0;
      if (transmit_enable_set)
        transmit_enable_bit <= 1'b1;
      case (state_ff)
        PTQ_IDLE:
          if (may_start)
          begin
            cur_ff <= txq.head;
            mac_pnum <= txq.head;
            mac_start <= 1'b1;
            state_ff <= PTQ_BUSY;
          end
        PTQ_BUSY:
          if (done_bad)
          begin
            transmit_enable_bit <= 1'b0;
            state_ff <= PTQ_STOPPED;
          end
          else if (done_ok)
          begin
            gap_ff <= IFG_W'(IFG_CYC);
            state_ff <= PTQ_GAP;
          end
        PTQ_GAP:
          if (gap_ff == IFG_W'(1))
            state_ff <= PTQ_IDLE;
          else
            gap_ff <= gap_ff - IFG_W'(1);
        PTQ_STOPPED:
          // leave once host re-enables; a re-enqueue or release may follow
          if (transmit_enable_set)
            state_ff <= PTQ_IDLE;
        default:
          state_ff <= PTQ_IDLE;
      endcase
    end
  end

  // status word writeback and host-visible queue flags
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stat_we <= 1'b0;
      stat_pnum <= PNUM_NONE;
      stat_addr <= STATUS_OFS;
      stat_data <= '0;
      tx_int <= 1'b0;
      completion_fifo_empty <= 1'b1;
      tx_fifo_port <= PNUM_NONE;
      tx_queue_drained_flag <= 1'b0;
    end
    else
    begin
      stat_we <= (done_ok && !auto_release) || done_bad;
      stat_pnum <= cur_ff;
      stat_addr <= STATUS_OFS;
      stat_data <= mac_status;
      // both from the same next-cycle emptiness so they never disagree
      tx_int <= !cmpq_empty_nxt || fail_int_nxt;
      completion_fifo_empty <= cmpq_empty_nxt && !fail_int_nxt;
      tx_fifo_port <= fail_int_nxt ? cur_ff : cmpq_head_nxt;
      // set wins over clear
      if (drain_evt)
        tx_queue_drained_flag <= 1'b1;
      else if (host_ack_drained)
        tx_queue_drained_flag <= 1'b0;
    end
  end

  // failure pending flag; set wins over an acknowledge in the same cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      fail_pend_ff <= 1'b0;
    else if (done_bad)
      fail_pend_ff <= 1'b1;
    else if (host_ack_tx_int && cmpq.empty)
      fail_pend_ff <= 1'b0;
  end

  // duplex mode controls to the mac
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mac_loopback <= 1'b0;
      mac_carrier_sense_en <= 1'b1;
      mac_collision_en <= 1'b1;
    end
    else
    begin
      mac_loopback <= diag_loopback_duplex && !switched_full_duplex;
      mac_carrier_sense_en <= !switched_full_duplex;
      mac_collision_en <= !switched_full_duplex;
    end
  end
endmodule : ptq_top

// File: shared/ptq_fifo_if.sv
// ptq_fifo_if: push/pop/peek signals of one packet-number fifo.
// assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface ptq_fifo_if;
  import ptq_pkg::*;
  logic push;
  logic pop;
  logic [PNUM_W-1:0] wdata;
  logic [PNUM_W-1:0] head;
  logic empty;
  logic full;
  logic last; // exactly one entry held
  modport owner (output push, output pop, output wdata, input head, input empty, input full,
    input last);
  modport fifo (input push, input pop, input wdata, output head, output empty, output full,
    output last);
endinterface : ptq_fifo_if

// File: shared/ptq_pkg.sv
// ptq_pkg: constants and types for the packet transmit queue controller.
// assumes a single clock domain; shared by the top module and the fifo module.
package ptq_pkg;
  localparam int PNUM_W = 6;                 // packet number width
  localparam int NPKT = 8;                   // packet numbers in the pool
  localparam int PIDX_W = 3;                 // index into the pool
  localparam int FIFO_DEPTH = 8;             // entries in each number fifo
  localparam int CNT_W = 4;                  // fifo occupancy width
  localparam int LEN_W = 11;                 // byte count width
  localparam int PAGE_BYTES = 256;           // ram page size in bytes
  localparam int NPAGE = 24;                 // pages in the shared ram
  localparam int PAGE_W = 5;                 // page count width
  localparam int PTR_W = 11;                 // byte pointer width
  localparam int STAT_W = 16;                // transmit status word width
  localparam logic [PTR_W-1:0] STATUS_OFS = 11'h000; // status word sits first
  localparam real IFG_NS = 9600.0;           // interframe gap, 96 bit times at 10 Mb/s
  localparam real CLK_NS = 25.0;             // clock period
  localparam int IFG_CYC = int'($ceil(IFG_NS / CLK_NS)); // least time, rounded up
  localparam int IFG_W = 9;
  localparam logic [PNUM_W-1:0] PNUM_NONE = 6'h00;

  typedef enum logic [1:0] {PTQ_CMD_NONE, PTQ_CMD_ALLOC, PTQ_CMD_ENQ, PTQ_CMD_RELEASE} ptq_cmd_t;
  typedef enum {PTQ_IDLE, PTQ_WAIT_MAC, PTQ_BUSY, PTQ_GAP, PTQ_STOPPED} ptq_state_t;
endpackage : ptq_pkg

// File: test/packet_tx_queue_duplex_ctrl_tb_top.sv
// testbench for ptq_top: host command sequences with expected results.
// assumes ptq_mac_model on the mac side and the checker bound to ptq_top.
`timescale 1ns/1ps
module packet_tx_queue_duplex_ctrl_tb_top;
  import ptq_pkg::*;
  logic clk, rstn, host_pnum_we, host_ptr_we, host_ack_tx_int, host_ack_drained;
  logic transmit_enable_set, diag_loopback_duplex, switched_full_duplex, auto_release;
  logic rx_page_req, rx_page_free, mac_defer, mac_done, mac_fail, transmit_enable_bit;
  logic alloc_done_flag, alloc_failed, tx_int, completion_fifo_empty, tx_queue_drained_flag;
  logic rx_page_grant, mac_start, mac_loopback, mac_carrier_sense_en, mac_collision_en;
  logic stat_we, fail_next, slow, busy;
  ptq_cmd_t host_cmd;
  logic [LEN_W-1:0] host_alloc_len;
  logic [PTR_W-1:0] host_ptr_wr, data_addr, stat_addr;
  logic [STAT_W-1:0] mac_status, stat_data;
  logic [PNUM_W-1:0] host_pnum_wr, alloc_result, pnum_reg, tx_fifo_port, mac_pnum, stat_pnum;
  logic [PNUM_W-1:0] pn [NPKT];
  int bad_count = 0;
  int compares = 0;
  int n;

  ptq_top ptq_top_inst (.*);
  ptq_mac_model ptq_mac_model_inst (.clk(clk), .rstn(rstn), .fail_next(fail_next),
    .slow(slow), .busy(busy), .mac_start(mac_start), .mac_defer(mac_defer),
    .mac_done(mac_done), .mac_fail(mac_fail), .mac_status(mac_status));

  // free-running system clock
  always #12.5 clk = ~clk;

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : cyc
  task automatic chk1(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1
  task automatic chkn(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chkn
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse
  // packet number first, then the command one cycle later
  task automatic cmd(input ptq_cmd_t c, input logic [PNUM_W-1:0] p);
    host_pnum_wr = p;
    pulse(host_pnum_we);
    host_cmd = c;
    cyc(1);
    host_cmd = PTQ_CMD_NONE;
  endtask : cmd
  // bounded wait for a level or a one-cycle pulse
  task automatic wait_on(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1 && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask : wait_on
  task automatic finish_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // cut a hang short well past the expected run length
  initial
  begin
    #(25.0 * 20000);
    bad_count++;
    finish_test();
  end

  // main sequence
  initial
  begin
    {clk, rstn, host_pnum_we, host_ptr_we, host_ack_tx_int, host_ack_drained} = '0;
    {transmit_enable_set, diag_loopback_duplex, switched_full_duplex, auto_release} = '0;
    {rx_page_req, rx_page_free, fail_next, slow, busy} = '0;
    host_cmd = PTQ_CMD_NONE;
    host_alloc_len = 11'h064;
    host_ptr_wr = 11'h005;
    host_pnum_wr = 6'h00;
    cyc(10);
    rstn = 1'b1;
    cyc(1);
    chk1("empty_rst", 1'b1, completion_fifo_empty);
    chk1("int_rst", 1'b0, tx_int);
    pulse(rx_page_req);
    chk1("rx_grant", 1'b1, rx_page_grant);
    pulse(rx_page_free);
    // whole number pool, then one refused allocation
    for (int i = 0; i <= NPKT; i++)
    begin
      cmd(PTQ_CMD_ALLOC, 6'h00);
      chk1("alloc_done", i < NPKT, alloc_done_flag);
      if (i < NPKT)
        pn[i] = alloc_result;
    end
    chk1("alloc_failed", 1'b1, alloc_failed);
    cmd(PTQ_CMD_RELEASE, pn[7]);
    chkn("pnum_reg", 16'(pn[7]), 16'(pnum_reg));
    cmd(PTQ_CMD_ALLOC, 6'h00);
    chk1("realloc", 1'b1, alloc_done_flag);
    pn[7] = alloc_result;
    pulse(host_ptr_we);
    chkn("data_addr", 16'h0005, 16'(data_addr));
    // enqueue while disabled, then while deferring, then clear
    cmd(PTQ_CMD_ENQ, pn[0]);
    wait_on(mac_start, 20);
    chk1("start_off", 1'b0, mac_start);
    diag_loopback_duplex = 1'b1;
    busy = 1'b1;
    pulse(transmit_enable_set);
    wait_on(mac_start, 20);
    chk1("start_defer", 1'b0, mac_start);
    busy = 1'b0;
    wait_on(mac_start, 10);
    chkn("mac_pnum", 16'(pn[0]), 16'(mac_pnum));
    wait_on(stat_we, 20);
    chkn("stat_pnum", 16'(pn[0]), 16'(stat_pnum));
    chk1("tx_int", 1'b1, tx_int);
    chkn("port", 16'(pn[0]), 16'(tx_fifo_port));
    pulse(host_ack_tx_int);
    chk1("int_ack", 1'b0, tx_int);
    cmd(PTQ_CMD_RELEASE, pn[0]);
    // switched duplex back to back, deferral ignored, gap kept
    diag_loopback_duplex = 1'b0;
    switched_full_duplex = 1'b1;
    busy = 1'b1;
    slow = 1'b1;
    cmd(PTQ_CMD_ENQ, pn[1]);
    cmd(PTQ_CMD_ENQ, pn[2]);
    wait_on(mac_start, 500);
    chk1("start_switched_full_duplex", 1'b1, mac_start);
    wait_on(stat_we, 60);
    wait_on(mac_start, 1000);
    chk1("gap", 1'b1, n >= IFG_CYC - 2 && n <= IFG_CYC + 4);
    chkn("mac_pnum2", 16'(pn[2]), 16'(mac_pnum));
    wait_on(stat_we, 60);
    pulse(host_ack_tx_int);
    cyc(1);
    chkn("port2", 16'(pn[2]), 16'(tx_fifo_port));
    pulse(host_ack_tx_int);
    chk1("empty2", 1'b1, completion_fifo_empty);
    // failure stops the queue until the host recovers
    busy = 1'b0;
    fail_next = 1'b1;
    cmd(PTQ_CMD_ENQ, pn[3]);
    wait_on(tx_int, 500);
    fail_next = 1'b0;
    chk1("fail_int", 1'b1, tx_int);
    chk1("fail_en", 1'b0, transmit_enable_bit);
    chkn("fail_port", 16'(pn[3]), 16'(tx_fifo_port));
    cmd(PTQ_CMD_ENQ, pn[4]);
    wait_on(mac_start, 450);
    chk1("stopped", 1'b0, mac_start);
    pulse(host_ack_tx_int);
    cmd(PTQ_CMD_ENQ, pn[3]);
    pulse(transmit_enable_set);
    wait_on(mac_start, 450);
    chk1("restart", 1'b1, mac_start);
    chkn("restart_pnum", 16'(pn[4]), 16'(mac_pnum));
    repeat (2)
    begin
      wait_on(tx_int, 500);
      pulse(host_ack_tx_int);
    end
    chk1("drained_int", 1'b0, tx_int);
    // auto release: no completion entry, drained flag instead
    auto_release = 1'b1;
    cmd(PTQ_CMD_ENQ, pn[5]);
    wait_on(tx_queue_drained_flag, 600);
    chk1("drained", 1'b1, tx_queue_drained_flag);
    chk1("auto_int", 1'b0, tx_int);
    pulse(host_ack_drained);
    chk1("drained_clr", 1'b0, tx_queue_drained_flag);
    finish_test();
  end
endmodule : packet_tx_queue_duplex_ctrl_tb_top

// File: test/ptq_checker.sv
// ptq_checker: port-level assertions for the transmit queue controller.
// assumes one clock domain; bound onto ptq_top at the foot of this file.
`timescale 1ns/1ps
module ptq_checker
  import ptq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // host and mac inputs
  input wire ptq_pkg::ptq_cmd_t host_cmd,
  input wire logic diag_loopback_duplex,
  input wire logic switched_full_duplex,
  input wire logic auto_release,
  input wire logic mac_defer,
  input wire logic mac_done,
  input wire logic mac_fail,
  input wire logic [STAT_W-1:0] mac_status,
  // outputs watched
  input wire logic transmit_enable_bit,
  input wire logic alloc_done_flag,
  input wire logic alloc_failed,
  input wire logic tx_int,
  input wire logic completion_fifo_empty,
  input wire logic mac_start,
  input wire logic mac_loopback,
  input wire logic mac_carrier_sense_en,
  input wire logic mac_collision_en,
  input wire logic stat_we,
  input wire logic [PTR_W-1:0] stat_addr,
  input wire logic [STAT_W-1:0] stat_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // completion kinds as seen from the mac side
  sequence s_ok_done;
    mac_done && !mac_fail && !auto_release;
  endsequence
  sequence s_fail_done;
    mac_done && mac_fail;
  endsequence
  // allocation answers with exactly one of done or refused
  property p_alloc;
    host_cmd == PTQ_CMD_ALLOC |=> alloc_done_flag != alloc_failed;
  endproperty
  a_alloc: assert property (p_alloc) else $error("alloc answer wrong");
  property p_status;
    s_ok_done |=> stat_we && stat_addr == STATUS_OFS && stat_data == $past(mac_status);
  endproperty
  a_status: assert property (p_status) else $error("status word not written");
  property p_done_int;
    s_ok_done |=> tx_int && !completion_fifo_empty;
  endproperty
  a_done_int: assert property (p_done_int) else $error("completion not queued");
  // failure also raises the interrupt and clears completion_fifo_empty, so the pairing holds through it; it is checked while enabled
  property p_int_eq;
    transmit_enable_bit |-> tx_int == !completion_fifo_empty;
  endproperty
  a_int_eq: assert property (p_int_eq) else $error("interrupt and empty disagree");
  property p_fail;
    s_fail_done |=> !transmit_enable_bit && tx_int;
  endproperty
  a_fail: assert property (p_fail) else $error("failure not handled");
  property p_start_en;
    mac_start |-> transmit_enable_bit;
  endproperty
  a_start_en: assert property (p_start_en) else $error("start while disabled");
  property p_defer;
    mac_start && !switched_full_duplex |-> !$past(mac_defer);
  endproperty
  a_defer: assert property (p_defer) else $error("start during deferral");
  property p_switched_full_duplex;
    switched_full_duplex [*2] |-> !mac_loopback && !mac_carrier_sense_en && !mac_collision_en;
  endproperty
  a_switched_full_duplex: assert property (p_switched_full_duplex) else $error("switched duplex controls wrong");
  property p_diag;
    (diag_loopback_duplex && !switched_full_duplex) [*2] |-> mac_loopback && mac_carrier_sense_en;
  endproperty
  a_diag: assert property (p_diag) else $error("diagnostic loopback wrong");
endmodule : ptq_checker

bind ptq_top ptq_checker ptq_checker_inst (.*);

// File: test/ptq_mac_model.sv
// ptq_mac_model: behavioural transmit mac that answers each start once.
// assumes starts are one-cycle pulses; fail_next and slow set by the bench.
`timescale 1ns/1ps
module ptq_mac_model
  import ptq_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bench controls
  input wire logic fail_next,
  input wire logic slow,
  input wire logic busy,
  // mac side of the block
  input wire logic mac_start,
  output logic mac_defer,
  output logic mac_done,
  output logic mac_fail,
  output logic [STAT_W-1:0] mac_status
);
  int cnt_ff;
  // frame time counter, short or long so both answer speeds occur
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cnt_ff <= 0;
    else if (mac_start)
      cnt_ff <= slow ? 40 : 3;
    else if (cnt_ff != 0)
      cnt_ff <= cnt_ff - 1;
  end
  // status is junk outside the done pulse so stale reads show up
  assign mac_defer = busy; // carrier seen on the medium
  assign mac_done = (cnt_ff == 1);
  assign mac_fail = mac_done && fail_next;
  assign mac_status = mac_done ? {15'h0000, !fail_next} : ~16'(cnt_ff);
endmodule : ptq_mac_model
